// >>> rucc_pkg.sv
// Shared constants, register map and types for the remote update configuration controller
package rucc_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WDT = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_CMD = 8'h0C;
	localparam logic [7:0] ADDR_ISTAT = 8'h10;
	localparam logic [7:0] ADDR_IMASK = 8'h14;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CMD_START_BIT = 0;
	localparam int CMD_RESTART_BIT = 1;
	localparam int CMD_KICK_BIT = 2;
	localparam int WDT_EN_BIT = 12;
	localparam int CLKSEL_LSB = 13;
	localparam int STAT_APP_BIT = 3;
	localparam int STAT_USER_BIT = 4;
	localparam int IRQ_USER_BIT = 0;
	localparam int IRQ_RECONF_BIT = 1;
	localparam logic [23:0] CTRL_RST = 24'h000000;
	localparam logic [11:0] WDT_SET_RST = 12'h000;
	localparam logic [1:0] IMASK_RST = 2'h0;
	localparam logic [23:0] FACTORY_ADDR = 24'h000000;
	localparam logic [7:0] WDT_LOW_ZERO = 8'h00;
	localparam int CLK_PERIOD_NS = 4;
	localparam int OSC40_PERIOD_NS = 25;
	localparam int OSC20_PERIOD_NS = 50;
	// Shortest legal half period, rounded up so the link never exceeds its rate
	localparam logic [3:0] HALF40_CYC = 4'((OSC40_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
	localparam logic [3:0] HALF20_CYC = 4'((OSC20_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS));
	localparam logic [3:0] RELOAD_CYC = 4'h8;
	typedef enum logic [1:0] {CLK_OSC40 = 2'b00, CLK_OSC20 = 2'b01, CLK_USER = 2'b10} rucc_clksel_t;
	typedef enum logic [2:0] {
		CAUSE_NONE = 3'b000,
		CAUSE_CRC = 3'b001,
		CAUSE_WDT = 3'b010,
		CAUSE_STATUS = 3'b011,
		CAUSE_RESTART = 3'b100
	} rucc_cause_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_LOAD = 3'b001,
		S_WAIT = 3'b010,
		S_USER = 3'b011,
		S_CAUSE = 3'b100,
		S_RELOAD = 3'b101
	} rucc_state_t;
	typedef struct packed {
		logic [3:0] cnt;
		logic sclk;
	} rucc_gen_t;
	typedef struct packed {
		rucc_state_t st;
		logic [23:0] ctrl;
		logic [11:0] wdt_set;
		logic wdt_en;
		logic [1:0] clk_sel;
		rucc_cause_t cause;
		rucc_cause_t pcause;
		logic img_app;
		logic tgt_app;
		logic [23:0] mem_addr;
		logic [15:0] bit_cnt;
		logic par;
		logic [19:0] wdt_cnt;
		logic [3:0] rl_cnt;
		logic [1:0] ist;
		logic [1:0] imask;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rucc_st_t;
endpackage : rucc_pkg

// >>> rucc_clk_if.sv
// Link clock control between the controller and its clock generator
`timescale 1ns/1ps
interface rucc_clk_if;
	logic [1:0] sel;
	logic usr;
	logic run;
	logic tick;
	logic sclk;
	modport src (input sel, input usr, input run, output tick, output sclk);
	modport snk (output sel, output usr, output run, input tick, input sclk);
endinterface : rucc_clk_if

// >>> rucc_sync.sv
// Two-flop synchroniser for a group of external inputs
`timescale 1ns/1ps
module rucc_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} rucc_sync_t;
	rucc_sync_t s_q;
	rucc_sync_t s_d;
	always_comb
	begin
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign dout = s_q.s2;
endmodule : rucc_sync

// >>> rucc_sclk_gen.sv
// Serial link clock generator: internal oscillator divider or user clock follower
`timescale 1ns/1ps
module rucc_sclk_gen
	import rucc_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Control
	rucc_clk_if.src c
);
	rucc_gen_t s_q;
	rucc_gen_t s_d;
	logic [3:0] half;
	logic tick;
	always_comb
	begin
		s_d = s_q;
		tick = 1'b0;
		half = (c.sel == CLK_OSC20) ? HALF20_CYC : HALF40_CYC;
		if (!c.run)
		begin
			s_d.cnt = 4'h0;
			s_d.sclk = 1'b0;
		end
		else if (c.sel == CLK_USER)
		begin
			// A level already high at frame start is no edge; the data path also needs three cycles to settle
			if (s_q.cnt != 4'h4)
			begin
				if (s_q.cnt != 4'h3)
					s_d.cnt = s_q.cnt + 4'h1;
				else if (!c.usr)
					s_d.cnt = 4'h4;
			end
			else
			begin
				s_d.sclk = c.usr;
				tick = c.usr && !s_q.sclk;
			end
		end
		else if (s_q.cnt == half - 4'h1)
		begin
			s_d.cnt = 4'h0;
			s_d.sclk = !s_q.sclk;
			tick = !s_q.sclk;
		end
		else
			s_d.cnt = s_q.cnt + 4'h1;
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign c.tick = tick;
	assign c.sclk = s_q.sclk;
endmodule : rucc_sclk_gen

// >>> rucc_top.sv
// Remote update configuration controller with AXI4-Lite register access
// Operation
// - Serial link clock from 40 or 20 MHz oscillator divider or user clock.
// - Shared complete flag must read high before user mode is entered.
// - After loading, drive chip enable output low to start the next device.
// - Successful completion in chain order also drives chip enable output low.
// - Load error of an image records its cause code in hardware.
// - Status line low, CRC error, watchdog timeout, restart all record a cause.
// - Every error reloads the factory image.
// - Error-free load enters user mode.
// - Control, status, watchdog and sequencing live in this hard block.
`timescale 1ns/1ps
module rucc_top
	import rucc_pkg::*;
#(
	parameter int unsigned IMAGE_BITS = 1024
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// Configuration memory link
	input wire logic user_clock_input,
	output logic config_serial_clock,
	input wire logic config_data_in,
	output logic mem_select_n,
	output logic [23:0] mem_addr,
	// Chain pins
	input wire logic chip_enable_in_n,
	output logic chip_enable_out_n,
	input wire logic config_complete_flag_i,
	output logic config_complete_flag_o,
	output logic config_complete_flag_oe,
	input wire logic config_status_n_i,
	output logic config_status_n_o,
	output logic config_status_n_oe,
	input wire logic config_restart_n,
	// Status
	output logic user_mode,
	output logic irq
);
	rucc_st_t s_q;
	rucc_st_t n;
	rucc_clk_if clk_if ();
	logic [5:0] syn;
	logic usr_s;
	logic data_s;
	logic ce_s;
	logic done_s;
	logic stat_s;
	logic rst_s;
	logic kick;
	logic swrst;
	logic start;
	logic last;
	logic wdt_hit;
	logic [1:0] clr;
	logic [1:0] iset;
	logic [31:0] m;
	logic [31:0] wv;
	logic [31:0] cur;

	function automatic logic [31:0] bmask(input logic [3:0] s);
		bmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction : bmask

	rucc_sync #(
		.W(6)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din({user_clock_input, config_data_in, chip_enable_in_n, config_complete_flag_i,
			config_status_n_i, config_restart_n}),
		.dout(syn)
	);
	assign {usr_s, data_s, ce_s, done_s, stat_s, rst_s} = syn;

	rucc_sclk_gen u_gen (
		.aclk(aclk),
		.aresetn(aresetn),
		.c(clk_if.src)
	);
	assign clk_if.sel = s_q.clk_sel;
	assign clk_if.usr = usr_s;
	assign clk_if.run = (s_q.st == S_LOAD);

	assign last = (s_q.bit_cnt == 16'(IMAGE_BITS - 1));
	assign wdt_hit = s_q.img_app && s_q.wdt_en && (s_q.wdt_cnt == {s_q.wdt_set, WDT_LOW_ZERO});

	always_comb
	begin
		n = s_q;
		kick = 1'b0;
		swrst = 1'b0;
		start = 1'b0;
		clr = 2'h0;
		iset = 2'h0;
		m = 32'h0;
		wv = 32'h0;
		cur = 32'h0;
		// Write channels are taken independently, answered once both are held
		if (s_axi_awvalid && !s_q.aw_have)
		begin
			n.aw_have = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s_q.w_have)
		begin
			n.w_have = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (s_q.bvalid && s_axi_bready)
			n.bvalid = 1'b0;
		if (s_q.aw_have && s_q.w_have && !s_q.bvalid)
		begin
			m = bmask(s_q.wstrb);
			wv = s_q.wdata & m;
			n.aw_have = 1'b0;
			n.w_have = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			if (s_q.aw_addr == ADDR_CTRL)
				n.ctrl = (s_q.ctrl & ~m[23:0]) | wv[23:0];
			else if (s_q.aw_addr == ADDR_WDT)
			begin
				cur = {17'h00000, s_q.clk_sel, s_q.wdt_en, s_q.wdt_set};
				cur = (cur & ~m) | wv;
				n.wdt_set = cur[11:0];
				n.wdt_en = cur[WDT_EN_BIT];
				n.clk_sel = cur[CLKSEL_LSB+1:CLKSEL_LSB];
			end
			else if (s_q.aw_addr == ADDR_CMD)
			begin
				start = wv[CMD_START_BIT];
				swrst = wv[CMD_RESTART_BIT];
				kick = wv[CMD_KICK_BIT];
			end
			else if (s_q.aw_addr == ADDR_IMASK)
				n.imask = (s_q.imask & ~m[1:0]) | wv[1:0];
			else if (s_q.aw_addr != ADDR_STAT && s_q.aw_addr != ADDR_ISTAT)
				n.bresp = RESP_SLVERR;
		end
		if (s_q.rvalid && s_axi_rready)
			n.rvalid = 1'b0;
		if (s_axi_arvalid && !s_q.rvalid)
		begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			n.rdata = 32'h0;
			if (s_axi_araddr == ADDR_CTRL)
				n.rdata = {8'h00, s_q.ctrl};
			else if (s_axi_araddr == ADDR_WDT)
				n.rdata = {17'h00000, s_q.clk_sel, s_q.wdt_en, s_q.wdt_set};
			else if (s_axi_araddr == ADDR_STAT)
				n.rdata = {27'h0000000, s_q.st == S_USER, s_q.img_app, s_q.cause};
			else if (s_axi_araddr == ADDR_ISTAT)
			begin
				n.rdata = {30'h00000000, s_q.ist};
				clr = 2'h3;
			end
			else if (s_axi_araddr == ADDR_IMASK)
				n.rdata = {30'h00000000, s_q.imask};
			else if (s_axi_araddr != ADDR_CMD)
				n.rresp = RESP_SLVERR;
		end
		// Watchdog runs only for an application image that enabled it
		if (kick || s_q.st != S_USER || !s_q.img_app || !s_q.wdt_en)
			n.wdt_cnt = 20'h00000;
		else
			n.wdt_cnt = s_q.wdt_cnt + 20'h00001;
		case (s_q.st)
			S_IDLE:
			begin
				// Waits for the chain enable and for the status line to be released
				if (!ce_s && stat_s && rst_s)
				begin
					n.st = S_LOAD;
					n.img_app = s_q.tgt_app;
					n.mem_addr = s_q.tgt_app ? s_q.ctrl : FACTORY_ADDR;
					n.bit_cnt = 16'h0000;
					n.par = 1'b0;
				end
			end
			S_LOAD:
			begin
				if (!stat_s)
				begin
					n.pcause = CAUSE_STATUS;
					n.st = S_CAUSE;
				end
				else if (clk_if.tick)
				begin
					n.par = s_q.par ^ data_s;
					n.bit_cnt = s_q.bit_cnt + 16'h0001;
					if (last && (s_q.par ^ data_s))
					begin
						n.pcause = CAUSE_CRC;
						n.st = S_CAUSE;
					end
					else if (last)
						n.st = S_WAIT;
				end
			end
			S_WAIT:
			begin
				if (!stat_s)
				begin
					n.pcause = CAUSE_STATUS;
					n.st = S_CAUSE;
				end
				else if (done_s)
				begin
					n.st = S_USER;
					iset[IRQ_USER_BIT] = 1'b1;
				end
			end
			S_USER:
			begin
				if (!stat_s)
				begin
					n.pcause = CAUSE_STATUS;
					n.st = S_CAUSE;
				end
				else if (wdt_hit)
				begin
					n.pcause = CAUSE_WDT;
					n.st = S_CAUSE;
				end
				else if (start && !s_q.img_app)
				begin
					n.tgt_app = 1'b1;
					n.rl_cnt = 4'h0;
					n.st = S_RELOAD;
				end
			end
			S_CAUSE:
			begin
				// Cause lands on the same edge that starts the reload so it is never stale
				n.cause = s_q.pcause;
				n.tgt_app = 1'b0;
				n.rl_cnt = 4'h0;
				n.st = S_RELOAD;
				iset[IRQ_RECONF_BIT] = 1'b1;
			end
			S_RELOAD:
			begin
				n.rl_cnt = s_q.rl_cnt + 4'h1;
				if (s_q.rl_cnt == RELOAD_CYC - 4'h1)
					n.st = S_IDLE;
			end
			default:
				n.st = S_IDLE;
		endcase
		// Restart pin or software restart aborts any active phase
		if ((!rst_s || swrst) && (s_q.st == S_LOAD || s_q.st == S_WAIT || s_q.st == S_USER))
		begin
			n.pcause = CAUSE_RESTART;
			n.st = S_CAUSE;
		end
		n.ist = (s_q.ist & ~clr) | iset;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.ctrl <= CTRL_RST;
			s_q.wdt_set <= WDT_SET_RST;
			s_q.imask <= IMASK_RST;
		end
		else
			s_q <= n;
	end

	assign s_axi_awready = !s_q.aw_have;
	assign s_axi_wready = !s_q.w_have;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign config_serial_clock = clk_if.sclk;
	assign mem_select_n = (s_q.st != S_LOAD);
	assign mem_addr = s_q.mem_addr;
	// Open-drain lines: value is always low, the enable does the driving
	assign config_complete_flag_o = 1'b0;
	assign config_complete_flag_oe = (s_q.st != S_WAIT) && (s_q.st != S_USER);
	assign config_status_n_o = 1'b0;
	assign config_status_n_oe = (s_q.st == S_RELOAD);
	assign chip_enable_out_n = !((s_q.st == S_WAIT) || (s_q.st == S_USER));
	assign user_mode = (s_q.st == S_USER);
	assign irq = |(s_q.ist & s_q.imask);

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_sclk_rate;
		(s_q.clk_sel == CLK_OSC40 && config_serial_clock)[*4] |=> !config_serial_clock;
	endproperty
	a_sclk_rate: assert property (p_sclk_rate) else $error("link clock high too long");
	property p_hold_user;
		(s_q.st == S_WAIT && !done_s) |=> s_q.st != S_USER;
	endproperty
	a_hold_user: assert property (p_hold_user) else $error("user mode before chain done");
	property p_ce_out;
		(s_q.st == S_LOAD && $past(s_q.st) == S_LOAD) |-> chip_enable_out_n;
	endproperty
	a_ce_out: assert property (p_ce_out) else $error("chip enable out low during load");
	property p_chain_done;
		$rose(s_q.st == S_WAIT) |-> !chip_enable_out_n && !config_complete_flag_oe;
	endproperty
	a_chain_done: assert property (p_chain_done) else $error("chain outputs wrong after load");
	property p_crc;
		(s_q.st == S_LOAD && stat_s && rst_s && clk_if.tick && last && (s_q.par ^ data_s))
			|=> s_q.st == S_CAUSE ##1 s_q.cause == CAUSE_CRC;
	endproperty
	a_crc: assert property (p_crc) else $error("crc error not recorded");
	property p_wdt;
		(s_q.st == S_USER && stat_s && rst_s && wdt_hit) |=> ##1 s_q.cause == CAUSE_WDT;
	endproperty
	a_wdt: assert property (p_wdt) else $error("watchdog timeout not recorded");
	property p_factory;
		s_q.st == S_CAUSE |=> !s_q.tgt_app ##[1:16] (s_q.st == S_IDLE && !s_q.tgt_app);
	endproperty
	a_factory: assert property (p_factory) else $error("error did not target factory");
	property p_user;
		(s_q.st == S_WAIT && done_s && stat_s && rst_s) |=> user_mode;
	endproperty
	a_user: assert property (p_user) else $error("good load did not enter user mode");
	property p_kick;
		(s_q.st == S_USER && $past(kick)) |-> s_q.wdt_cnt == 20'h00000;
	endproperty
	a_kick: assert property (p_kick) else $error("watchdog not cleared by kick");
	property p_cause_first;
		$rose(s_q.st == S_RELOAD) && $past(s_q.st) == S_CAUSE |-> s_q.cause == $past(s_q.pcause);
	endproperty
	a_cause_first: assert property (p_cause_first) else $error("cause not written before reload");
	property p_app_user;
		s_q.st == S_USER && s_q.img_app;
	endproperty
	c_app_user: cover property (p_app_user);
	property p_wdt_seen;
		s_q.st == S_CAUSE && s_q.pcause == CAUSE_WDT;
	endproperty
	c_wdt_seen: cover property (p_wdt_seen);
	property p_crc_seen;
		s_q.st == S_CAUSE && s_q.pcause == CAUSE_CRC;
	endproperty
	c_crc_seen: cover property (p_crc_seen);
endmodule : rucc_top

// >>> rucc_mem_model.sv
// Serial configuration memory model that feeds image bits over the link
`timescale 1ns/1ps
module rucc_mem_model #(
	parameter int N = 16
) (
	// Clock
	input wire logic aclk,
	// Link
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic corrupt,
	output logic data
);
	int idx;
	logic par, sclk_q, sel_q, nb;
	initial data = 1'b0;
	always @(posedge aclk)
	begin
		sclk_q <= sclk;
		sel_q <= sel_n;
		if (sel_n)
		begin
			// Released line toggles so a stale bit is never mistaken for data
			data <= ~data;
			idx <= 0;
			par <= 1'b0;
		end
		else if (sel_q || (sclk_q && !sclk))
		begin
			// Next bit set up on the falling edge, held over the rise; last bit closes even parity
			nb = (idx == N - 1) ? (par ^ corrupt) : (idx[0] ^ idx[2]);
			data <= nb;
			par <= par ^ nb;
			idx <= idx + 1;
		end
	end
endmodule : rucc_mem_model

// >>> tb_rucc_top.sv
// Self-checking bench for the remote update configuration controller
`timescale 1ns/1ps
module tb_rucc_top
	import rucc_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0, uclk = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic ce_in_n = 1'b1, restart_n = 1'b1, peer_hold = 1'b1, ext_low = 1'b0, corrupt = 1'b0;
	logic user_clock_input, config_serial_clock, config_data_in, mem_select_n, chip_enable_out_n;
	logic [23:0] mem_addr;
	logic cc_i, cc_o, cc_oe, st_i, st_o, st_oe, user_mode, irq;
	int n_fail = 0, checked = 0, cyc = 0, rl_n = 0;
	initial forever #2 aclk = ~aclk;
	initial
	begin
		#1.3;
		forever #32 uclk = ~uclk;
	end
	// User clock runs free, as a board oscillator would
	assign user_clock_input = uclk;
	// Open-drain lines with pull-ups, each shared with an outside driver that can hold it low
	assign cc_i = !(cc_oe && !cc_o) && !peer_hold;
	assign st_i = !(st_oe && !st_o) && !ext_low;
	rucc_top #(.IMAGE_BITS(16)) u_rucc_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .user_clock_input(user_clock_input),
		.config_serial_clock(config_serial_clock), .config_data_in(config_data_in),
		.mem_select_n(mem_select_n), .mem_addr(mem_addr), .chip_enable_in_n(ce_in_n),
		.chip_enable_out_n(chip_enable_out_n), .config_complete_flag_i(cc_i), .config_complete_flag_o(cc_o),
		.config_complete_flag_oe(cc_oe), .config_status_n_i(st_i), .config_status_n_o(st_o),
		.config_status_n_oe(st_oe), .config_restart_n(restart_n), .user_mode(user_mode), .irq(irq));
	rucc_mem_model #(.N(16)) u_rucc_mem_model (.aclk(aclk), .sclk(config_serial_clock),
		.sel_n(mem_select_n), .corrupt(corrupt), .data(config_data_in));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic conclude();
		$display("counts checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			conclude();
		end
	end
	// Every reload pulse on the status line must last its fixed length
	always @(posedge aclk)
		if (st_oe)
			rl_n <= rl_n + 1;
		else if (rl_n != 0)
		begin
			chk("reload_len", 32'(rl_n), 32'(RELOAD_CYC));
			rl_n <= 0;
		end
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axi_rd
	task automatic t_boot();
		repeat (20) @(posedge aclk);
		chk("idle_no_load", 32'(mem_select_n), 32'h1);
		ce_in_n <= 1'b0;
		@(posedge aclk iff !mem_select_n);
		chk("factory_addr", 32'(mem_addr), 32'(FACTORY_ADDR));
		@(posedge aclk iff mem_select_n);
		repeat (4) @(posedge aclk);
		chk("wait_pins", 32'({chip_enable_out_n, cc_oe, user_mode}), 32'h0);
		peer_hold <= 1'b0;
		@(posedge aclk iff user_mode);
		axi_rd(ADDR_STAT, rd, rs);
		chk("boot_status", rd, 32'h10);
		$display("test boot done");
	endtask : t_boot
	task automatic t_irq();
		chk("irq_masked", 32'(irq), 32'h0);
		axi_wr(ADDR_IMASK, 32'h1, 4'hF, rs);
		@(posedge aclk);
		chk("irq_on", 32'(irq), 32'h1);
		axi_rd(ADDR_ISTAT, rd, rs);
		chk("istat", rd, 32'h1);
		@(posedge aclk);
		chk("irq_off", 32'(irq), 32'h0);
		axi_rd(ADDR_ISTAT, rd, rs);
		chk("istat_clr", rd, 32'h0);
		$display("test irq done");
	endtask : t_irq
	task automatic t_regs();
		axi_rd(ADDR_CTRL, rd, rs);
		chk("ctrl_rst", rd, 32'(CTRL_RST));
		axi_wr(ADDR_CTRL, 32'hFFA55A3C, 4'hF, rs);
		chk("wr_resp", 32'(rs), 32'(RESP_OKAY));
		axi_wr(ADDR_CTRL, 32'h00001100, 4'h2, rs);
		axi_rd(ADDR_CTRL, rd, rs);
		chk("ctrl_lanes", rd, 32'h00A5113C);
		axi_wr(ADDR_WDT, 32'hFFFFFFFF, 4'hF, rs);
		axi_rd(ADDR_WDT, rd, rs);
		chk("wdt_rw", rd, 32'h00007FFF);
		axi_wr(ADDR_WDT, 32'h0, 4'hF, rs);
		axi_wr(8'h18, 32'h1, 4'hF, rs);
		chk("unmapped_wr", 32'(rs), 32'(RESP_SLVERR));
		axi_rd(8'h18, rd, rs);
		chk("unmapped_rd", {rd[29:0], rs}, 32'(RESP_SLVERR));
		axi_rd(ADDR_CMD, rd, rs);
		chk("cmd_rd", rd, 32'h0);
		$display("test regs done");
	endtask : t_regs
	task automatic go_app(input logic [23:0] a, input logic [31:0] w);
		axi_wr(ADDR_CTRL, 32'(a), 4'hF, rs);
		axi_wr(ADDR_WDT, w, 4'hF, rs);
		axi_wr(ADDR_CMD, 32'h1, 4'hF, rs);
		@(posedge aclk iff !mem_select_n);
		chk("app_addr", 32'(mem_addr), 32'(a));
	endtask : go_app
	task automatic t_app(input logic [23:0] a, input logic [31:0] w, input int per);
		time t0;
		go_app(a, w);
		// First link edge may follow a partial period
		@(posedge config_serial_clock);
		@(posedge config_serial_clock);
		t0 = $time;
		@(posedge config_serial_clock);
		chk("sclk_period", 32'(($time - t0) / CLK_PERIOD_NS), 32'(per));
		@(posedge aclk iff user_mode);
		axi_rd(ADDR_STAT, rd, rs);
		chk("app_status", rd & 32'h18, 32'h18);
		axi_rd(ADDR_ISTAT, rd, rs);
		chk("app_istat", rd, 32'h1);
	endtask : t_app
	task automatic t_factory(input logic [2:0] c);
		@(posedge aclk iff mem_select_n);
		@(posedge aclk iff !mem_select_n);
		chk("reload_addr", 32'(mem_addr), 32'(FACTORY_ADDR));
		@(posedge aclk iff user_mode);
		axi_rd(ADDR_STAT, rd, rs);
		chk("cause", rd, 32'h10 | 32'(c));
		axi_rd(ADDR_ISTAT, rd, rs);
		chk("reconf_irq", rd, 32'h3);
	endtask : t_factory
	task automatic t_restart_cmd();
		t_app(24'h000100, 32'h2000, 2 * HALF20_CYC);
		axi_wr(ADDR_CMD, 32'h2, 4'hF, rs);
		t_factory(CAUSE_RESTART);
		$display("test restart_cmd done");
	endtask : t_restart_cmd
	task automatic t_restart_pin();
		t_app(24'h000200, 32'h0, 2 * HALF40_CYC);
		restart_n <= 1'b0;
		repeat (2) @(posedge aclk);
		restart_n <= 1'b1;
		t_factory(CAUSE_RESTART);
		$display("test restart_pin done");
	endtask : t_restart_pin
	task automatic t_status_low();
		t_app(24'h000300, 32'h0, 2 * HALF40_CYC);
		ext_low <= 1'b1;
		repeat (2) @(posedge aclk);
		ext_low <= 1'b0;
		t_factory(CAUSE_STATUS);
		$display("test status_low done");
	endtask : t_status_low
	task automatic t_wdt();
		t_app(24'h000400, 32'h1001, 2 * HALF40_CYC);
		repeat (3)
		begin
			repeat (200) @(posedge aclk);
			axi_wr(ADDR_CMD, 32'h4, 4'hF, rs);
		end
		chk("kicked_alive", 32'(user_mode), 32'h1);
		t_factory(CAUSE_WDT);
		$display("test wdt done");
	endtask : t_wdt
	task automatic t_crc();
		corrupt <= 1'b1;
		go_app(24'h000500, 32'h0);
		// Bad parity rides on the last bit, so hold it until the frame closes
		@(posedge aclk iff mem_select_n);
		corrupt <= 1'b0;
		t_factory(CAUSE_CRC);
		$display("test crc done");
	endtask : t_crc
	initial
	begin
		repeat (16) @(posedge aclk);
		chk("reset_outs", 32'({s_axi_awready, s_axi_bvalid, s_axi_rvalid, config_serial_clock, mem_select_n,
			chip_enable_out_n, cc_oe, st_oe, user_mode, irq}), 32'h238);
		aresetn <= 1'b1;
		t_boot();
		t_irq();
		t_regs();
		t_restart_cmd();
		t_restart_pin();
		t_status_low();
		t_wdt();
		t_crc();
		t_app(24'h000600, 32'h4000, 16);
		$display("test user_clock done");
		conclude();
	end
endmodule : tb_rucc_top
